// ===== rtl/ecpp_top.sv
// host port, serial stream ports and clock crossings of the echo canceller
//
// Overview of operation
// RULE1 - port activity is ignored while the active-low chip select is high
// RULE2 - reads and writes happen only while strobe and chip select are both low
// RULE3 - read/write pin sets data bus direction: device drives reads, samples writes
// RULE4 - open-drain transfer acknowledge pulls low when the transfer has completed
// RULE5 - one eight-bit bidirectional data bus serves every register access
// RULE6 - eleven address inputs are decoded to select internal registers
// RULE7 - serial outputs enabled only when enable pin and control bit 6 both high
// RULE8 - serial outputs float whenever enable pin or control bit is low
// RULE9 - send output carries port 1 data, 2.048 Mb/s, eight channels
// RULE10 - receive output carries port 2 data, 2.048 Mb/s, eight channels
// RULE11 - send input takes port 2 data, 2.048 Mb/s, eight channels
// RULE12 - receive input takes port 1 data, 2.048 Mb/s, eight channels
// RULE13 - frame pulse polarity format is identified automatically, no configuration
// RULE14 - the 4.096 MHz serial clock shifts all four serial streams
// RULE15 - core runs on an asynchronous master clock; stream data crosses safely
// RULE16 - frequency select low means 20 MHz master clock, high means 10 MHz
// RULE17 - interrupt output low while any channel event is queued unread
// RULE18 - each bit spans two serial clocks, msb first, slots counted from frame
// RULE19 - acknowledge released once strobe or chip select goes high
`timescale 1ns/1ns
module ecpp_top #(
  parameter int unsigned LOSS_CYC_20M = ecpp_pkg::LOSS_CYC_LO,
  parameter int unsigned LOSS_CYC_10M = ecpp_pkg::LOSS_CYC_HI
) (
  input  wire logic                        mclk_i,
  input  wire logic                        rst_b_i,
  input  wire logic                        fsel_i,
  input  wire logic                        cs_n_i,
  input  wire logic                        host_strobe_n_i,
  input  wire logic                        host_rd_wr_i,
  input  wire logic [ecpp_pkg::ADDR_W-1:0] host_addr_bus_i,
  input  wire logic [ecpp_pkg::DATA_W-1:0] host_data_bus_i,
  output logic      [ecpp_pkg::DATA_W-1:0] host_data_bus_o,
  output logic                             host_data_bus_oe_n_o,
  output logic                             transfer_ack_n_o,
  output logic                             transfer_ack_oe_n_o,
  input  wire logic [ecpp_pkg::CHANNELS-1:0] chan_irq_i,
  output logic                             irq_n_o,
  output logic                             irq_oe_n_o,
  input  wire logic                        serial_bit_clock_i,
  input  wire logic                        frame_sync_in_i,
  input  wire logic                        serial_out_enable_i,
  input  wire logic                        send_in_i,
  input  wire logic                        recv_in_i,
  output logic                             send_out_o,
  output logic                             send_out_oe_n_o,
  output logic                             recv_out_o,
  output logic                             recv_out_oe_n_o
);
  import ecpp_pkg::*;

  if (LOSS_CYC_20M < 2 || LOSS_CYC_10M < 2 || LOSS_CYC_20M >= 2**LOSS_W
      || LOSS_CYC_10M >= 2**LOSS_W) begin : g_chk
    $error("ecpp_top: loss counts out of range");
  end

  function automatic logic in_page(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    in_page = (a & ADDR_PAGE_MASK) == base;
  endfunction : in_page

  // ---------------- master clock domain ----------------
  logic                 rst_meta;
  logic                 rst_n;
  ecpp_host_in_t        host_meta;
  ecpp_host_in_t        hs;
  ecpp_hp_state_t       state;
  ecpp_hp_state_t       next_state;
  logic                 sel;
  logic                 wr_stb;
  logic                 irq_rd_stb;
  logic [ADDR_W-1:0]    acc_addr;
  logic                 acc_rd;
  logic [DATA_W-1:0]    ctrl;
  logic [DATA_W-1:0]    next_rdata;
  logic [DATA_W-1:0]    sin_rdata;
  logic [DATA_W-1:0]    rin_rdata;
  logic [CHANNELS-1:0]  pending;
  logic [CHANNELS-1:0]  clr_mask;
  logic [CH_W-1:0]      first_ch;
  logic                 fsel_meta;
  logic                 fsel_m;
  ecpp_frame_stat_t     fstat_meta;
  ecpp_frame_stat_t     fstat_m;
  logic                 ft_meta;
  logic                 ft_sync;
  logic                 ft_prev;
  logic [LOSS_W-1:0]    loss_cnt;
  logic [LOSS_W-1:0]    loss_limit;
  logic                 lost;
  ecpp_frame_stat_t     fstat_l;
  logic                 frame_tgl;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // host pins are asynchronous to the master clock
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      host_meta <= HOST_IN_IDLE;
      hs        <= HOST_IN_IDLE;
      fsel_meta <= 1'b0;
      fsel_m    <= 1'b0;
    end else begin
      host_meta <= '{cs_n: cs_n_i, strobe_n: host_strobe_n_i, rd: host_rd_wr_i,
                     addr: host_addr_bus_i, data: host_data_bus_i};
      hs        <= host_meta;
      fsel_meta <= fsel_i;
      fsel_m    <= fsel_meta;
    end
  end

  assign sel        = !hs.cs_n && !hs.strobe_n; // RULE1 RULE2
  assign wr_stb     = (state == HP_IDLE) && sel && !hs.rd; // RULE3
  assign irq_rd_stb = (state == HP_WAIT) && acc_rd && (acc_addr == ADDR_IRQQ);

  always_comb begin
    next_state = state;
    unique case (state)
      HP_IDLE: next_state = sel ? HP_WAIT : HP_IDLE;
      HP_WAIT: next_state = sel ? HP_ACK : HP_IDLE; // RULE19
      HP_ACK:  next_state = sel ? HP_ACK : HP_IDLE; // RULE19
      default: next_state = HP_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= HP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      acc_addr <= '0;
      acc_rd   <= 1'b1;
    end else if (state == HP_IDLE && sel) begin
      acc_addr <= hs.addr; // RULE6
      acc_rd   <= hs.rd;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (wr_stb && hs.addr == ADDR_CTRL) begin
      ctrl <= hs.data; // RULE5
    end
  end

  always_comb begin
    first_ch = '0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (pending[i]) begin
        first_ch = CH_W'(i);
      end
    end
  end

  always_comb begin
    clr_mask = '0;
    if (irq_rd_stb && |pending) begin
      clr_mask[first_ch] = 1'b1;
    end
  end

  // a new event in the cycle its entry is read stays queued
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~clr_mask) | chan_irq_i; // RULE17
    end
  end

  assign irq_n_o    = 1'b0;
  assign irq_oe_n_o = !(|pending); // RULE17

  always_comb begin
    next_rdata = UNMAPPED_READ;
    if (acc_addr == ADDR_CTRL) begin
      next_rdata = ctrl;
    end else if (acc_addr == ADDR_STAT) begin
      next_rdata[STAT_LOCK_BIT] = fstat_m.locked;
      next_rdata[STAT_GCI_BIT]  = fstat_m.gci;
      next_rdata[STAT_LOST_BIT] = lost;
      next_rdata[STAT_FSEL_BIT] = fsel_m;
    end else if (acc_addr == ADDR_IRQQ) begin
      next_rdata[IRQQ_VALID_BIT] = |pending;
      next_rdata[CH_W-1:0]       = first_ch;
    end else if (in_page(acc_addr, ADDR_SIN_BASE)) begin
      next_rdata = sin_rdata;
    end else if (in_page(acc_addr, ADDR_RIN_BASE)) begin
      next_rdata = rin_rdata;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      host_data_bus_o <= '0;
    end else if (state == HP_WAIT && acc_rd) begin
      host_data_bus_o <= next_rdata; // RULE3 RULE5
    end
  end

  assign host_data_bus_oe_n_o = !(state == HP_ACK && acc_rd); // RULE3
  assign transfer_ack_n_o     = 1'b0;
  assign transfer_ack_oe_n_o  = !(state == HP_ACK); // RULE4 RULE19

  // frame status and frame event from the serial clock domain
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      fstat_meta <= '0;
      fstat_m    <= '0;
      ft_meta    <= 1'b0;
      ft_sync    <= 1'b0;
      ft_prev    <= 1'b0;
    end else begin
      fstat_meta <= fstat_l;
      fstat_m    <= fstat_meta;
      ft_meta    <= frame_tgl;
      ft_sync    <= ft_meta; // RULE15
      ft_prev    <= ft_sync;
    end
  end

  assign loss_limit = fsel_m ? LOSS_W'(LOSS_CYC_10M) : LOSS_W'(LOSS_CYC_20M); // RULE16

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      loss_cnt <= '0;
      lost     <= 1'b1;
    end else if (ft_sync != ft_prev) begin
      loss_cnt <= '0;
      lost     <= 1'b0;
    end else if (loss_cnt >= loss_limit) begin
      lost     <= 1'b1;
    end else begin
      loss_cnt <= loss_cnt + 1'b1;
    end
  end

  // ---------------- serial clock domain ----------------
  logic                 lrst_meta;
  logic                 lrst_n;
  logic                 en_pin_meta;
  logic                 en_pin;
  logic                 en_bit_meta;
  logic                 en_bit;
  logic                 out_en;
  logic                 fp_q;
  logic [RUN_W-1:0]     run;
  logic                 frame_start;
  logic [CNT_W-1:0]     cnt;
  logic                 slot_active;
  logic [CH_W-1:0]      tx_raddr;
  logic [DATA_W-1:0]    sout_rdata;
  logic [DATA_W-1:0]    rout_rdata;
  logic [DATA_W-1:0]    send_sh;
  logic [DATA_W-1:0]    recv_sh;
  logic [DATA_W-1:0]    sin_sh;
  logic [DATA_W-1:0]    rin_sh;
  logic                 rx_we;

  always_ff @(posedge serial_bit_clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lrst_meta <= 1'b0;
      lrst_n    <= 1'b0;
    end else begin
      lrst_meta <= 1'b1;
      lrst_n    <= lrst_meta;
    end
  end

  always_ff @(posedge serial_bit_clock_i or negedge lrst_n) begin
    if (!lrst_n) begin
      en_pin_meta <= 1'b0;
      en_pin      <= 1'b0;
      en_bit_meta <= 1'b0;
      en_bit      <= 1'b0;
      out_en      <= 1'b0;
    end else begin
      en_pin_meta <= serial_out_enable_i;
      en_pin      <= en_pin_meta;
      en_bit_meta <= ctrl[CTRL_OUT_EN_BIT];
      en_bit      <= en_bit_meta;
      out_en      <= en_pin && en_bit; // RULE7 RULE8
    end
  end

  assign send_out_oe_n_o = !out_en; // RULE8
  assign recv_out_oe_n_o = !out_en; // RULE8

  // a short level ending marks the frame pulse; its level gives the format
  assign frame_start = (frame_sync_in_i != fp_q) && (run < PULSE_MAX_CLKS); // RULE13

  always_ff @(posedge serial_bit_clock_i or negedge lrst_n) begin
    if (!lrst_n) begin
      fp_q      <= 1'b1;
      run       <= '1;
      cnt       <= '0;
      fstat_l   <= '0;
      frame_tgl <= 1'b0;
    end else begin
      fp_q <= frame_sync_in_i;
      if (frame_sync_in_i != fp_q) begin
        run <= '0;
      end else if (run != '1) begin
        run <= run + 1'b1;
      end
      if (frame_start) begin
        cnt            <= '0; // RULE18
        fstat_l.locked <= 1'b1;
        fstat_l.gci    <= fp_q; // RULE13
        frame_tgl      <= !frame_tgl;
      end else begin
        cnt <= cnt + 1'b1; // RULE14
      end
    end
  end

  assign slot_active = cnt[CNT_W-1:SLOT_LSB] < SLOT_W'(CHANNELS);
  assign tx_raddr    = CH_W'(cnt[SLOT_LSB+CH_W-1:SLOT_LSB] + 1'b1);

  // output bits change on even clocks so each bit stands two serial clocks
  always_ff @(posedge serial_bit_clock_i or negedge lrst_n) begin
    if (!lrst_n) begin
      send_sh <= IDLE_BYTE;
      recv_sh <= IDLE_BYTE;
    end else if (cnt[SLOT_LSB-1:0] == SLOT_FIRST) begin
      send_sh <= slot_active ? sout_rdata : IDLE_BYTE; // RULE9
      recv_sh <= slot_active ? rout_rdata : IDLE_BYTE; // RULE10
    end else if (!cnt[0]) begin
      send_sh <= {send_sh[DATA_W-2:0], 1'b1}; // RULE18
      recv_sh <= {recv_sh[DATA_W-2:0], 1'b1};
    end
  end

  assign send_out_o = send_sh[DATA_W-1];
  assign recv_out_o = recv_sh[DATA_W-1];

  // inputs sampled mid-bit on odd clocks
  always_ff @(posedge serial_bit_clock_i or negedge lrst_n) begin
    if (!lrst_n) begin
      sin_sh <= '0;
      rin_sh <= '0;
    end else if (cnt[0]) begin
      sin_sh <= {sin_sh[DATA_W-2:0], send_in_i}; // RULE11
      rin_sh <= {rin_sh[DATA_W-2:0], recv_in_i}; // RULE12
    end
  end

  assign rx_we = slot_active && (cnt[SLOT_LSB-1:0] == SLOT_LAST) && fstat_l.locked;

  // channel bytes cross between domains through dual-clock memories
  ecpp_chan_ram #(.DW(DATA_W), .AW(CH_W)) u_sout_ram ( // RULE15
    .wclk_i  (mclk_i),
    .we_i    (wr_stb && in_page(hs.addr, ADDR_SOUT_BASE)),
    .waddr_i (hs.addr[CH_W-1:0]),
    .wdata_i (hs.data),
    .rclk_i  (serial_bit_clock_i),
    .raddr_i (tx_raddr),
    .rdata_o (sout_rdata)
  );

  ecpp_chan_ram #(.DW(DATA_W), .AW(CH_W)) u_rout_ram (
    .wclk_i  (mclk_i),
    .we_i    (wr_stb && in_page(hs.addr, ADDR_ROUT_BASE)),
    .waddr_i (hs.addr[CH_W-1:0]),
    .wdata_i (hs.data),
    .rclk_i  (serial_bit_clock_i),
    .raddr_i (tx_raddr),
    .rdata_o (rout_rdata)
  );

  ecpp_chan_ram #(.DW(DATA_W), .AW(CH_W)) u_sin_ram (
    .wclk_i  (serial_bit_clock_i),
    .we_i    (rx_we),
    .waddr_i (cnt[SLOT_LSB+CH_W-1:SLOT_LSB]),
    .wdata_i ({sin_sh[DATA_W-2:0], send_in_i}),
    .rclk_i  (mclk_i),
    .raddr_i (hs.addr[CH_W-1:0]),
    .rdata_o (sin_rdata)
  );

  ecpp_chan_ram #(.DW(DATA_W), .AW(CH_W)) u_rin_ram (
    .wclk_i  (serial_bit_clock_i),
    .we_i    (rx_we),
    .waddr_i (cnt[SLOT_LSB+CH_W-1:SLOT_LSB]),
    .wdata_i ({rin_sh[DATA_W-2:0], recv_in_i}),
    .rclk_i  (mclk_i),
    .raddr_i (hs.addr[CH_W-1:0]),
    .rdata_o (rin_rdata)
  );

  // ---------------- checks ----------------
  property p_idle_no_ack;
    @(posedge mclk_i) disable iff (!rst_n)
      (!sel && state != HP_ACK) |=> transfer_ack_oe_n_o;
  endproperty
  a_idle_no_ack: assert property (p_idle_no_ack) else $error("ack without select"); // RULE1

  property p_ack_after_sel;
    @(posedge mclk_i) disable iff (!rst_n)
      (state == HP_IDLE && sel) |=> ##1 !transfer_ack_oe_n_o;
  endproperty
  a_ack_after_sel: assert property (p_ack_after_sel) else $error("ack late"); // RULE4

  property p_ack_release;
    @(posedge mclk_i) disable iff (!rst_n)
      (state == HP_ACK && !sel) |=> transfer_ack_oe_n_o && host_data_bus_oe_n_o;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack held"); // RULE19

  property p_write_no_drive;
    @(posedge mclk_i) disable iff (!rst_n)
      wr_stb |=> ##1 host_data_bus_oe_n_o;
  endproperty
  a_write_no_drive: assert property (p_write_no_drive) else $error("drove on write"); // RULE3

  property p_ctrl_write;
    @(posedge mclk_i) disable iff (!rst_n)
      (wr_stb && hs.addr == ADDR_CTRL) |=> ctrl == $past(hs.data);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl not written"); // RULE6

  property p_ctrl_readback;
    @(posedge mclk_i) disable iff (!rst_n)
      (state == HP_WAIT && acc_rd && acc_addr == ADDR_CTRL) |=> host_data_bus_o == ctrl;
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("bad read data"); // RULE5

  property p_irq_event;
    @(posedge mclk_i) disable iff (!rst_n)
      (chan_irq_i != '0) |=> !irq_oe_n_o;
  endproperty
  a_irq_event: assert property (p_irq_event) else $error("event lost"); // RULE17

  property p_out_gate;
    @(posedge serial_bit_clock_i) disable iff (!lrst_n)
      !(en_pin && en_bit) |=> send_out_oe_n_o && recv_out_oe_n_o;
  endproperty
  a_out_gate: assert property (p_out_gate) else $error("outputs not floated"); // RULE8

  property p_bit_span;
    @(posedge serial_bit_clock_i) disable iff (!lrst_n)
      (cnt[0] && !frame_start) |=> $stable(send_out_o) && $stable(recv_out_o);
  endproperty
  a_bit_span: assert property (p_bit_span) else $error("bit shorter than two clocks"); // RULE18

endmodule : ecpp_top

// ===== rtl/ecpp_pkg.sv
// shared constants, types and address map of the echo canceller pin-side ports
package ecpp_pkg;

  // host port shape
  localparam int ADDR_W   = 11;
  localparam int DATA_W   = 8;
  localparam int CHANNELS = 8;
  localparam int CH_W     = 3;

  // host address map
  localparam logic [ADDR_W-1:0] ADDR_CTRL      = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_STAT      = 11'h001;
  localparam logic [ADDR_W-1:0] ADDR_IRQQ      = 11'h002;
  localparam logic [ADDR_W-1:0] ADDR_SOUT_BASE = 11'h010;
  localparam logic [ADDR_W-1:0] ADDR_ROUT_BASE = 11'h018;
  localparam logic [ADDR_W-1:0] ADDR_SIN_BASE  = 11'h020;
  localparam logic [ADDR_W-1:0] ADDR_RIN_BASE  = 11'h028;
  localparam logic [ADDR_W-1:0] ADDR_PAGE_MASK = 11'h7F8;

  // field positions and values
  localparam int CTRL_OUT_EN_BIT = 6;
  localparam int STAT_LOCK_BIT  = 0;
  localparam int STAT_GCI_BIT   = 1;
  localparam int STAT_LOST_BIT  = 2;
  localparam int STAT_FSEL_BIT  = 3;
  localparam int IRQQ_VALID_BIT = 7;
  localparam logic [DATA_W-1:0] CTRL_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
  localparam logic [DATA_W-1:0] IDLE_BYTE     = 8'hFF;

  // serial frame: 512 serial clocks per 125 us frame, 16 clocks per timeslot
  localparam int CNT_W      = 9;
  localparam int SLOT_LSB   = 4;
  localparam int SLOT_W     = 5;
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [3:0] SLOT_LAST  = 4'hF;
  localparam int RUN_W      = 3;
  localparam logic [RUN_W-1:0] PULSE_MAX_CLKS = 3'h4;

  // frame loss watchdog, counted at the nominal master clock chosen by the select pin
  localparam int LOSS_TIME_US = 250;
  localparam int FSEL_LO_MHZ  = 20;
  localparam int FSEL_HI_MHZ  = 10;
  localparam int LOSS_CYC_LO  = LOSS_TIME_US * FSEL_LO_MHZ;
  localparam int LOSS_CYC_HI  = LOSS_TIME_US * FSEL_HI_MHZ;
  localparam int LOSS_W       = 16;

  typedef enum logic [2:0] {
    HP_IDLE = 3'b001,
    HP_WAIT = 3'b010,
    HP_ACK  = 3'b100
  } ecpp_hp_state_t;

  typedef struct packed {
    logic              cs_n;
    logic              strobe_n;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ecpp_host_in_t;

  localparam ecpp_host_in_t HOST_IN_IDLE = '{cs_n: 1'b1, strobe_n: 1'b1, rd: 1'b1,
                                             addr: '0, data: '0};

  typedef struct packed {
    logic locked;
    logic gci;
  } ecpp_frame_stat_t;

endpackage : ecpp_pkg

// ===== rtl/ecpp_chan_ram.sv
// small dual-clock channel byte memory with registered read data
`timescale 1ns/1ns
module ecpp_chan_ram #(
  parameter int DW = 8,
  parameter int AW = 3
) (
  input  wire logic          wclk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          rclk_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [2**AW];

  if (DW < 1 || AW < 1) begin : g_chk
    $error("ecpp_chan_ram: widths must be positive");
  end

  always_ff @(posedge wclk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge rclk_i) begin
    rdata_o <= mem[raddr_i];
  end

endmodule : ecpp_chan_ram

// ===== bench/ecpp_tdm_model.sv
// backplane model: serial clock, frame pulse, serial inputs, serial output capture
`timescale 1ns/1ns
module ecpp_tdm_model (
  input  wire logic        gci_i,
  input  wire logic        send_out_i,
  input  wire logic        send_oe_n_i,
  input  wire logic        recv_out_i,
  input  wire logic        recv_oe_n_i,
  output logic             sclk_o,
  output logic             fsync_o,
  output logic             send_in_o,
  output logic             recv_in_o,
  output logic [63:0]      sout_cap_o,
  output logic [63:0]      rout_cap_o,
  output int               frames_o
);
  int         t;
  int         k;
  logic [7:0] sb;
  logic [7:0] rb;
  initial begin
    sclk_o = 1'b0;
    forever #15 sclk_o = ~sclk_o;
  end
  initial begin
    fsync_o = 1'b1;
    send_in_o = 1'b1;
    recv_in_o = 1'b1;
    frames_o = 0;
    sout_cap_o = '0;
    rout_cap_o = '0;
    forever begin
      // one-clock pulse, low for the default format, high for the other
      @(negedge sclk_o) fsync_o = gci_i;
      @(negedge sclk_o) fsync_o = ~gci_i;
      for (t = 0; t < 510; t++) begin
        @(negedge sclk_o);
        // odd count of the previous edge: the middle of an output bit
        if (t > 0 && t < 129 && t % 2 == 0) begin
          k = ((t - 1) / 16) * 8 + 7 - ((t - 1) % 16) / 2;
          sout_cap_o[k] = send_out_i | send_oe_n_i;
          rout_cap_o[k] = recv_out_i | recv_oe_n_i;
        end
        sb = 8'(8'hA0 + t / 16);
        rb = 8'(8'h50 + t / 16);
        // each bit stands two clocks, msb first; idle slots are ones
        send_in_o = (t < 128) ? sb[7 - (t % 16) / 2] : 1'b1;
        recv_in_o = (t < 128) ? rb[7 - (t % 16) / 2] : 1'b1;
      end
      frames_o++;
    end
  end
endmodule : ecpp_tdm_model

// ===== bench/testbench.sv
// self-checking bench for the host port and serial stream ports
`timescale 1ns/1ns
module testbench;
  import ecpp_pkg::*;
  logic              mclk, rst_b, fsel, cs_n, strobe_n, rd_wr, out_en_pin, gci;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        drv, dout, irq;
  logic              dout_oe_n, ack_n, ack_oe_n, irq_n, irq_oe_n, sclk, fs;
  logic              s_in, r_in, s_out, s_oe_n, r_out, r_oe_n;
  logic [63:0]       scap, rcap;
  int                frames, fail_count, check_count, ch;
  wire               ack = ack_oe_n ? 1'b1 : ack_n;
  wire  [7:0]        bus = dout_oe_n ? drv : dout;
  wire               irq_line = irq_oe_n ? 1'b1 : irq_n;

  ecpp_top #(.LOSS_CYC_20M(8000), .LOSS_CYC_10M(6000)) dut_u (
    .mclk_i(mclk), .rst_b_i(rst_b), .fsel_i(fsel), .cs_n_i(cs_n),
    .host_strobe_n_i(strobe_n), .host_rd_wr_i(rd_wr), .host_addr_bus_i(addr),
    .host_data_bus_i(bus), .host_data_bus_o(dout), .host_data_bus_oe_n_o(dout_oe_n),
    .transfer_ack_n_o(ack_n), .transfer_ack_oe_n_o(ack_oe_n), .chan_irq_i(irq),
    .irq_n_o(irq_n), .irq_oe_n_o(irq_oe_n), .serial_bit_clock_i(sclk),
    .frame_sync_in_i(fs), .serial_out_enable_i(out_en_pin), .send_in_i(s_in),
    .recv_in_i(r_in), .send_out_o(s_out), .send_out_oe_n_o(s_oe_n),
    .recv_out_o(r_out), .recv_out_oe_n_o(r_oe_n));

  ecpp_tdm_model bp_u (
    .gci_i(gci), .send_out_i(s_out), .send_oe_n_i(s_oe_n), .recv_out_i(r_out),
    .recv_oe_n_i(r_oe_n), .sclk_o(sclk), .fsync_o(fs), .send_in_o(s_in),
    .recv_in_o(r_in), .sout_cap_o(scap), .rout_cap_o(rcap), .frames_o(frames));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    while (ack !== lvl) begin
      @(negedge mclk);
      n++;
      if (n > 50) begin
        check(8'(ack), 8'(lvl));
        stop_test();
      end
    end
  endtask : wait_ack

  task automatic access(input logic rd, input logic [ADDR_W-1:0] a, input logic [7:0] wd,
                        output logic [7:0] rv);
    time t0;
    @(negedge mclk);
    cs_n = 1'b0;
    rd_wr = rd;
    addr = a;
    drv = wd;
    strobe_n = 1'b0;
    t0 = $time;
    wait_ack(1'b0);
    // acknowledge comes 4 to 5 master clocks after the pins go low
    check(8'(($time - t0) >= 16 && ($time - t0) <= 20), 8'h01);
    check(8'(dout_oe_n), 8'(!rd));
    rv = bus;
    strobe_n = 1'b1;
    cs_n = 1'b1;
    drv = ~wd;
    wait_ack(1'b1);
    check(8'(dout_oe_n), 8'h01);
    repeat (3) @(negedge mclk);
  endtask : access

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] v;
    access(1'b0, a, d, v);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] v;
    access(1'b1, a, 8'h00, v);
    check(v, exp);
  endtask : rd_chk

  task automatic wait_frames(input int k);
    int f0;
    int n;
    f0 = frames;
    for (n = 0; frames < f0 + k; n++) begin
      @(negedge mclk);
      if (n > 20000) begin
        check(8'h00, 8'h01);
        stop_test();
      end
    end
  endtask : wait_frames

  task automatic t_host;
    // first frame pulse fell inside reset: not locked, frame lost
    rd_chk(ADDR_STAT, 8'h04);
    wr(ADDR_CTRL, 8'h5A);
    rd_chk(ADDR_CTRL, 8'h5A);
    // strobe with chip select high must leave the port quiet
    @(negedge mclk);
    rd_wr = 1'b0;
    drv = 8'h00;
    strobe_n = 1'b0;
    repeat (20) @(negedge mclk);
    check(8'(ack), 8'h01);
    strobe_n = 1'b1;
    repeat (3) @(negedge mclk);
    rd_chk(ADDR_CTRL, 8'h5A);
    rd_chk(11'h7FF, UNMAPPED_READ);
    rd_chk(ADDR_CTRL | 11'h400, UNMAPPED_READ);
  endtask : t_host

  task automatic t_out_en;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, i[0] ? 8'h40 : 8'h00);
      out_en_pin = i[1];
      repeat (10) @(negedge sclk);
      check(8'({s_oe_n, r_oe_n}), i == 3 ? 8'h00 : 8'h03);
    end
  endtask : t_out_en

  task automatic t_serial;
    for (ch = 0; ch < 8; ch++) begin
      wr(ADDR_SOUT_BASE + 11'(ch), 8'(8'h30 + ch));
      wr(ADDR_ROUT_BASE + 11'(ch), 8'(8'hC0 + ch));
    end
    wait_frames(3);
    rd_chk(ADDR_STAT, 8'h01);
    for (ch = 0; ch < 8; ch++) begin
      check(scap[ch*8+:8], 8'(8'h30 + ch));
      check(rcap[ch*8+:8], 8'(8'hC0 + ch));
      rd_chk(ADDR_SIN_BASE + 11'(ch), 8'(8'hA0 + ch));
      rd_chk(ADDR_RIN_BASE + 11'(ch), 8'(8'h50 + ch));
    end
  endtask : t_serial

  task automatic t_gci;
    gci = 1'b1;
    fsel = 1'b1;
    wait_frames(3);
    rd_chk(ADDR_STAT, 8'h0B);
    rd_chk(ADDR_SIN_BASE + 11'h003, 8'hA3);
  endtask : t_gci

  task automatic t_irq;
    @(negedge mclk);
    irq = 8'h24;
    @(negedge mclk);
    irq = 8'h00;
    repeat (4) @(negedge mclk);
    check(8'(irq_line), 8'h00);
    rd_chk(ADDR_IRQQ, 8'h82);
    check(8'(irq_line), 8'h00);
    rd_chk(ADDR_IRQQ, 8'h85);
    check(8'(irq_line), 8'h01);
  endtask : t_irq

  initial begin
    {fail_count, check_count} = '0;
    {rst_b, fsel, out_en_pin, gci, rd_wr, addr, drv, irq} = '0;
    cs_n = 1'b1;
    strobe_n = 1'b1;
    // reset spans several serial clocks so both domains see it
    repeat (4) @(negedge sclk);
    @(negedge mclk) rst_b = 1'b1;
    repeat (5) @(negedge mclk);
    t_host();
    t_out_en();
    t_serial();
    t_gci();
    t_irq();
    stop_test();
  end
endmodule : testbench
